// [rtl/cic_top.sv]
// What this block does
// - twelve interrupt sources, each with its own enable and flag bit.
// - any reset leaves every interrupt disabled.
// - vectoring needs global enable, source enable, and group enable for peripherals.
// - flags set on their event regardless of any enable.
// - taking an interrupt flushes the prefetched instruction.
// - taking an interrupt clears the global enable in hardware.
// - taking an interrupt pushes the current program counter.
// - taking an interrupt loads the program counter with the vector.
// - flags stay set until software clears them; still-set flags retrigger.
// - with global enable clear, events only set flags, and enabled ones wake the core from sleep.
// - return from interrupt pops the stack and sets global enable.
// - pending enabled events are serviced once global enable is set.
// - interrupt wake executes PC+1 first, then vectors only if global enabled.
// - interrupt wake sets the timeout bit and clears the powerdown bit.
// - vectoring begins three instruction cycles after the event.
// - group enable masks or admits all peripheral-register sources for vectoring; wake from sleep ignores it.
`timescale 1ns/10ps
module cic_top
  import cic_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [11:0] src_event,
  input wire logic [12:0] core_pc,
  input wire logic return_from_interrupt,
  input wire logic sleep_enter,
  input wire logic in_sleep,
  output logic flush_prefetch,
  output logic stack_push,
  output logic [12:0] push_pc,
  output logic stack_pop,
  output logic pc_load,
  output logic [12:0] pc_load_value,
  output logic wake_up,
  output logic irq_pending
);

  // ****************************************
  // state
  // ****************************************
  cic_flag_if fl ();

  cic_state_type state;
  logic [1:0] tcy_cnt;
  logic global_irq_enable;
  logic peripheral_group_enable;
  logic [2:0] core_enable;
  logic [7:0] peripheral_irq_enable_1;
  logic peripheral_irq_enable_2;
  logic timeout_status_bit;
  logic powerdown_status_bit;

  // ****************************************
  // flag bank
  // ****************************************
  cic_flag_bank u_flags (
    .pclk(pclk),
    .presetn(presetn),
    .fl(fl)
  );

  // ****************************************
  // apb decode
  // ****************************************
  wire [9:0] reg_index = paddr[11:2];
  wire hit_status = (reg_index == `CIC_IDX_STATUS);
  wire hit_control = (reg_index == `CIC_IDX_CONTROL);
  wire hit_flags_1 = (reg_index == `CIC_IDX_FLAGS_1);
  wire hit_flags_2 = (reg_index == `CIC_IDX_FLAGS_2);
  wire hit_enable_1 = (reg_index == `CIC_IDX_ENABLE_1);
  wire hit_enable_2 = (reg_index == `CIC_IDX_ENABLE_2);
  wire hit_any = hit_status | hit_control | hit_flags_1 | hit_flags_2 | hit_enable_1 | hit_enable_2;
  // one wait state: the access completes on the second access-phase edge
  wire access_done = psel & penable & pready;
  wire wr_done = access_done & pwrite;
  wire wr_control = wr_done & hit_control;
  wire [7:0] wd = pwdata[7:0];

  // ****************************************
  // request logic
  // ****************************************
  wire [11:0] flags = fl.flags;
  wire [11:0] enables = {peripheral_irq_enable_2, peripheral_irq_enable_1, core_enable};
  wire [11:0] masked = flags & enables;
  wire core_req = |masked[`CIC_CORE_SRC-1:0];
  wire periph_req = peripheral_group_enable & (|masked[`CIC_NUM_SRC-1:`CIC_CORE_SRC]);
  wire any_req = core_req | periph_req;
  wire take_req = global_irq_enable & any_req;
  wire wake_req = in_sleep & (|masked);
  wire tcy_en = (tcy_cnt == 2'(`CIC_TCY_CLKS - 1));

  wire take_now = tcy_en & ((state == CIC_IDLE) & ~wake_req | (state == CIC_WAKE)) & take_req;
  wire wake_now = tcy_en & (state == CIC_IDLE) & wake_req;
  wire vector_now = tcy_en & (state == CIC_FLUSHED);

  // ****************************************
  // flag writes
  // ****************************************
  // core sources sit at control bits 2..0 in reverse order of source number
  wire [11:0] wr_mask_core = wr_control ? 12'h007 : 12'h000;
  wire [11:0] wr_mask_p1 = (wr_done & hit_flags_1) ? 12'h7F8 : 12'h000;
  wire [11:0] wr_mask_p2 = (wr_done & hit_flags_2) ? 12'h800 : 12'h000;
  assign fl.event_in = src_event;
  assign fl.wr_mask = wr_mask_core | wr_mask_p1 | wr_mask_p2;
  assign fl.wr_data = {wd[0], wd, wd[`CIC_CTL_FL_CHANGE], wd[`CIC_CTL_FL_EXT], wd[`CIC_CTL_FL_TIMER]};

  // ****************************************
  // read mux
  // ****************************************
  wire [7:0] rd_control = {global_irq_enable, peripheral_group_enable, core_enable[0], core_enable[1],
                           core_enable[2], flags[0], flags[1], flags[2]};
  wire [7:0] rd_status = {3'h0, timeout_status_bit, powerdown_status_bit, 3'h0};
  wire [7:0] rd_byte = hit_control ? rd_control :
                       hit_flags_1 ? flags[10:3] :
                       hit_flags_2 ? {7'h00, flags[11]} :
                       hit_enable_1 ? peripheral_irq_enable_1 :
                       hit_enable_2 ? {7'h00, peripheral_irq_enable_2} :
                       hit_status ? rd_status : 8'h00;

  // ****************************************
  // apb answer
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~hit_any;
      prdata <= (psel & penable & ~pready & ~pwrite) ? {24'h000000, rd_byte} : 32'h00000000;
    end
  end

  // ****************************************
  // enable registers
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      peripheral_irq_enable_1 <= `CIC_ENABLE_1_RST;
      peripheral_irq_enable_2 <= `CIC_ENABLE_2_RST;
      core_enable <= 3'(`CIC_CONTROL_RST >> `CIC_CTL_EN_CHANGE);
      peripheral_group_enable <= 1'b0;
    end else begin
      if (wr_done & hit_enable_1) begin
        peripheral_irq_enable_1 <= wd;
      end
      if (wr_done & hit_enable_2) begin
        peripheral_irq_enable_2 <= wd[0];
      end
      if (wr_control) begin
        core_enable <= {wd[`CIC_CTL_EN_CHANGE], wd[`CIC_CTL_EN_EXT], wd[`CIC_CTL_EN_TIMER]};
        peripheral_group_enable <= wd[`CIC_CTL_GROUP];
      end
    end
  end

  // hardware changes to the global enable take priority over a software write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      global_irq_enable <= 1'b0;
    end else if (return_from_interrupt) begin
      global_irq_enable <= 1'b1;
    end else if (take_now) begin
      global_irq_enable <= 1'b0;
    end else if (wr_control) begin
      global_irq_enable <= wd[`CIC_CTL_GLOBAL];
    end
  end

  // ****************************************
  // status bits
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timeout_status_bit <= `CIC_TIMEOUT_RST;
      powerdown_status_bit <= `CIC_POWERDOWN_RST;
    end else if (wake_now | sleep_enter) begin
      timeout_status_bit <= 1'b1;
      powerdown_status_bit <= 1'b0;
    end
  end

  // ****************************************
  // instruction cycle divider
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tcy_cnt <= 2'h0;
    end else begin
      tcy_cnt <= tcy_en ? 2'h0 : tcy_cnt + 2'h1;
    end
  end

  // ****************************************
  // vectoring sequence
  // ****************************************
  // event is flagged, then flush on one cycle boundary and vector on the next,
  // so vector code runs in the third instruction cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= CIC_IDLE;
      flush_prefetch <= 1'b0;
      stack_push <= 1'b0;
      push_pc <= 13'h0000;
      stack_pop <= 1'b0;
      pc_load <= 1'b0;
      pc_load_value <= 13'h0000;
      wake_up <= 1'b0;
      irq_pending <= 1'b0;
    end else begin
      flush_prefetch <= take_now;
      stack_push <= vector_now;
      pc_load <= vector_now;
      wake_up <= wake_now;
      stack_pop <= return_from_interrupt;
      irq_pending <= take_req;
      if (vector_now) begin
        push_pc <= core_pc;
        pc_load_value <= `CIC_VECTOR;
      end
      if (tcy_en) begin
        unique case (state)
          CIC_IDLE: begin
            if (wake_req) begin
              state <= CIC_WAKE;
            end else if (take_req) begin
              state <= CIC_FLUSHED;
            end
          end
          CIC_WAKE: begin
            // PC+1 executes during this cycle; vector only with global enable
            state <= take_req ? CIC_FLUSHED : CIC_IDLE;
          end
          CIC_FLUSHED: begin
            state <= CIC_IDLE;
          end
          default: begin
            state <= CIC_IDLE;
          end
        endcase
      end
    end
  end

endmodule

// [pkg/cic_defines.svh]
`ifndef CIC_DEFINES_SVH
`define CIC_DEFINES_SVH

// register indexes; the byte address is four times the index
`define CIC_IDX_STATUS 10'h003
`define CIC_IDX_CONTROL 10'h00B
`define CIC_IDX_FLAGS_1 10'h00C
`define CIC_IDX_FLAGS_2 10'h00D
`define CIC_IDX_ENABLE_1 10'h08C
`define CIC_IDX_ENABLE_2 10'h08D

// core_irq_control field positions
`define CIC_CTL_GLOBAL 7
`define CIC_CTL_GROUP 6
`define CIC_CTL_EN_TIMER 5
`define CIC_CTL_EN_EXT 4
`define CIC_CTL_EN_CHANGE 3
`define CIC_CTL_FL_TIMER 2
`define CIC_CTL_FL_EXT 1
`define CIC_CTL_FL_CHANGE 0

// status field positions and reset values
`define CIC_ST_TIMEOUT 4
`define CIC_ST_POWERDOWN 3
`define CIC_TIMEOUT_RST 1'b1
`define CIC_POWERDOWN_RST 1'b1

// reset values
`define CIC_ENABLE_1_RST 8'h00
`define CIC_ENABLE_2_RST 1'b0
`define CIC_CONTROL_RST 8'h00
`define CIC_FLAGS_RST 12'h000

// source layout: 3 core sources, 8 in group 1, 1 in group 2
`define CIC_NUM_SRC 12
`define CIC_CORE_SRC 3
`define CIC_FLAGS_1_LSB 3
`define CIC_FLAGS_2_BIT 11

// vector and timing
`define CIC_VECTOR 13'h0004
`define CIC_PC_W 13
`define CIC_CLK_NS 100
`define CIC_TCY_NS 400
`define CIC_TCY_CLKS (`CIC_TCY_NS / `CIC_CLK_NS)
`define CIC_LATENCY_TCY 3

`endif

// [pkg/cic_pkg.sv]
package cic_pkg;
  `include "cic_defines.svh"

  typedef enum logic [2:0] {
    CIC_IDLE = 3'b001,
    CIC_FLUSHED = 3'b010,
    CIC_WAKE = 3'b100
  } cic_state_type;

  typedef logic [`CIC_NUM_SRC-1:0] cic_src_type;
  typedef logic [`CIC_PC_W-1:0] cic_pc_type;
endpackage

// [pkg/cic_flag_if.sv]
`timescale 1ns/10ps
interface cic_flag_if;
  import cic_pkg::*;
  cic_src_type event_in;
  cic_src_type wr_mask;
  cic_src_type wr_data;
  cic_src_type flags;
  modport bank (input event_in, input wr_mask, input wr_data, output flags);
  modport ctrl (output event_in, output wr_mask, output wr_data, input flags);
endinterface

// [rtl/cic_flag_bank.sv]
`timescale 1ns/10ps
module cic_flag_bank
  import cic_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  cic_flag_if.bank fl
);
  cic_src_type flags;
  cic_src_type next_flags;

  // an event in the cycle of a software write wins over the write
  assign next_flags = ((flags & ~fl.wr_mask) | (fl.wr_data & fl.wr_mask)) | fl.event_in;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags <= `CIC_FLAGS_RST;
    end else begin
      flags <= next_flags;
    end
  end

  assign fl.flags = flags;
endmodule

// [verification/cic_checker.sv]
`timescale 1ns/10ps
module cic_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [12:0] core_pc,
  input wire logic return_from_interrupt,
  input wire logic in_sleep,
  input wire logic flush_prefetch,
  input wire logic stack_push,
  input wire logic [12:0] push_pc,
  input wire logic stack_pop,
  input wire logic pc_load,
  input wire logic [12:0] pc_load_value,
  input wire logic wake_up
);
  // ********************************
  // properties
  // ********************************
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  take_order_a: assert property (flush_prefetch |-> ##4 (stack_push && pc_load))
    else $error("push did not follow flush");
  vector_value_a: assert property (pc_load |-> stack_push && pc_load_value == 13'h0004)
    else $error("wrong vector load");
  push_capture_a: assert property (stack_push |-> push_pc == $past(core_pc))
    else $error("pushed pc is not the current pc");
  single_take_a: assert property (flush_prefetch |=> !flush_prefetch [*3])
    else $error("flush repeated inside one take");
  pop_follow_a: assert property (return_from_interrupt |=> stack_pop)
    else $error("return did not pop");
  ready_slot_a: assert property (pready |-> psel && penable && $past(psel && penable))
    else $error("pready outside access phase");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  rdata_idle_a: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside answer");
  wake_sleep_a: assert property (wake_up |-> $past(in_sleep))
    else $error("wake while awake");
  cover property (flush_prefetch);
  cover property (stack_pop);
  cover property (wake_up);
  cover property (pslverr);
endmodule

bind cic_top cic_checker i_cic_checker (.*);

// [verification/cic_core_model.sv]
`timescale 1ns/10ps
module cic_core_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic do_ret,
  input wire logic do_sleep,
  input wire logic stack_push,
  input wire logic [12:0] push_pc,
  input wire logic stack_pop,
  input wire logic pc_load,
  input wire logic [12:0] pc_load_value,
  input wire logic wake_up,
  output logic [12:0] core_pc,
  output logic return_from_interrupt,
  output logic sleep_enter,
  output logic in_sleep
);
  // ********************************
  // fetch, pc and return stack
  // ********************************
  logic [12:0] stk [8];
  logic [2:0] sp;
  // pc moves every awake cycle so a stale capture of push_pc shows up
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_pc <= 13'h0000;
      sp <= 3'h0;
      return_from_interrupt <= 1'b0;
      sleep_enter <= 1'b0;
      in_sleep <= 1'b0;
    end else begin
      return_from_interrupt <= do_ret;
      sleep_enter <= do_sleep;
      if (do_sleep) begin
        in_sleep <= 1'b1;
      end else if (wake_up) begin
        in_sleep <= 1'b0;
      end
      if (stack_push) begin
        stk[sp] <= push_pc;
        sp <= sp + 3'h1;
      end
      if (pc_load) begin
        core_pc <= pc_load_value;
      end else if (stack_pop) begin
        core_pc <= stk[sp - 3'h1];
        sp <= sp - 3'h1;
      end else if (!in_sleep) begin
        core_pc <= core_pc + 13'h0001;
      end
    end
  end
endmodule

// [verification/cic_top_bench.sv]
`timescale 1ns/10ps
`include "cic_defines.svh"
module cic_top_bench;
  import cic_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, do_ret = 1'b0, do_sleep = 1'b0;
  logic [11:0] paddr = 12'h000, src_event = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, flush_prefetch, stack_push, stack_pop, pc_load, wake_up, irq_pending;
  logic return_from_interrupt, sleep_enter, in_sleep;
  cic_pc_type core_pc, push_pc, pc_load_value;
  logic [32:0] rd_q[$], vec_q[$];
  logic [15:0] seed = 16'hD050;
  int mismatches = 0, checks_done = 0, cycles = 0, wakes = 0;
  always #50 pclk = ~pclk;
  cic_top i_cic_top (.*);
  cic_core_model i_cic_core_model (.*);
  // ********************************
  // helpers
  // ********************************
  function automatic logic [15:0] xs(input logic [15:0] s);
    logic [15:0] t;
    t = s ^ (s << 7);
    t = t ^ (t >> 9);
    xs = t ^ (t << 8);
  endfunction
  task automatic check(input logic [32:0] got, input logic [32:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // one idle cycle after release keeps psel from being assigned twice in one step
  task automatic apb(input logic wr, input logic [9:0] idx, input logic [7:0] d, input logic [32:0] exp);
    if (!wr) rd_q.push_back(exp);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [9:0] idx, input logic [7:0] d);
    apb(1'b1, idx, d, 33'h0);
  endtask
  task automatic rd(input logic [9:0] idx, input logic [7:0] d);
    apb(1'b0, idx, 8'h00, {25'h0, d});
  endtask
  task automatic ev(input logic [11:0] s);
    src_event <= s;
    @(posedge pclk);
    src_event <= 12'h000;
  endtask
  task automatic ret_wait;
    do_ret <= 1'b1;
    @(posedge pclk);
    do_ret <= 1'b0;
    repeat (16) @(posedge pclk);
  endtask
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 4000) begin
      mismatches++;
      stop_test;
    end
  end
  // an answer with no note pending compares against an impossible value
  always @(posedge pclk) begin
    if (pready === 1'b1 && pwrite === 1'b0) check({pslverr, prdata}, rd_q.size() ? rd_q.pop_front() : 33'h1FFFFFFFF);
    if (pc_load === 1'b1) check({20'h0, pc_load_value}, vec_q.size() ? vec_q.pop_front() : 33'h1FFFFFFFF);
    if (wake_up === 1'b1) wakes++;
  end
  // ********************************
  // scenarios
  // ********************************
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(`CIC_IDX_CONTROL, 8'h00);
    rd(`CIC_IDX_ENABLE_1, 8'h00);
    rd(`CIC_IDX_ENABLE_2, 8'h00);
    rd(`CIC_IDX_STATUS, 8'h18);
    apb(1'b0, 10'h001, 8'h00, 33'h100000000);
    for (int i = 0; i < 3; i++) begin
      seed = xs(seed);
      ev(seed[11:0]);
      rd(`CIC_IDX_CONTROL, {5'h00, seed[0], seed[1], seed[2]});
      rd(`CIC_IDX_FLAGS_1, seed[10:3]);
      rd(`CIC_IDX_FLAGS_2, {7'h00, seed[11]});
      wr(`CIC_IDX_CONTROL, 8'h00);
      wr(`CIC_IDX_FLAGS_1, 8'h00);
      wr(`CIC_IDX_FLAGS_2, 8'h00);
    end
    wr(`CIC_IDX_ENABLE_1, 8'hFF);
    rd(`CIC_IDX_ENABLE_1, 8'hFF);
    wr(`CIC_IDX_ENABLE_2, 8'h01);
    rd(`CIC_IDX_ENABLE_2, 8'h01);
    ev(12'h008);
    wr(`CIC_IDX_CONTROL, 8'h80);
    repeat (16) @(posedge pclk);
    check({32'h0, irq_pending}, 33'h0);
    vec_q.push_back(33'h0004);
    wr(`CIC_IDX_CONTROL, 8'hC0);
    repeat (16) @(posedge pclk);
    rd(`CIC_IDX_CONTROL, 8'h40);
    rd(`CIC_IDX_FLAGS_1, 8'h01);
    vec_q.push_back(33'h0004);
    ret_wait;
    wr(`CIC_IDX_FLAGS_1, 8'h00);
    ret_wait;
    rd(`CIC_IDX_CONTROL, 8'hC0);
    wr(`CIC_IDX_CONTROL, 8'h20);
    do_sleep <= 1'b1;
    @(posedge pclk);
    do_sleep <= 1'b0;
    ev(12'h001);
    repeat (16) @(posedge pclk);
    check(33'(wakes), 33'h1);
    rd(`CIC_IDX_STATUS, 8'h10);
    check(33'(vec_q.size()), 33'h0);
    stop_test;
  end
endmodule
